/* design/dip_pkg.sv */
package dip_pkg;

    localparam int unsigned CHANNELS          = 16;
    localparam int unsigned BYTE_W            = 8;
    localparam int unsigned TICK_W            = 8;

    // clock and time base
    localparam int unsigned CLK_MHZ           = 200;
    localparam int unsigned TICK_US           = 100;
    localparam int unsigned TICK_CYCLES       = TICK_US * CLK_MHZ;
    // 2 Hz blink: toggle every quarter second
    localparam int unsigned BLINK_HALF_MS     = 250;
    localparam int unsigned BLINK_HALF_TICKS  = (BLINK_HALF_MS * 1000) / TICK_US;

    // process image byte offsets
    localparam logic [15:0] IMG_OFS_LOW       = 16'h0000;
    localparam logic [15:0] IMG_OFS_HIGH      = 16'h0001;

    // object dictionary indices and subindices
    localparam logic [15:0] OBJ_IDX_LOW       = 16'h6000;
    localparam logic [15:0] OBJ_IDX_HIGH      = 16'h6001;
    localparam logic [15:0] OBJ_IDX_PARAM     = 16'h3100;
    localparam logic [7:0]  OBJ_SUB_PARAM     = 8'h01;
    localparam logic [7:0]  OBJ_SUB_FIRST     = 8'h01;
    localparam logic [7:0]  OBJ_SUB_LAST      = 8'h10;

    // input delay parameter layout
    localparam logic [7:0]  PARAM_RESET       = 8'h89;
    localparam int unsigned PARAM_EN_BIT      = 7;
    localparam int unsigned PARAM_CODE_MSB    = 3;

    localparam logic [3:0]  CODE_0P4MS        = 4'h6;
    localparam logic [3:0]  CODE_0P7MS        = 4'h7;
    localparam logic [3:0]  CODE_1P5MS        = 4'h8;
    localparam logic [3:0]  CODE_3MS          = 4'h9;
    localparam logic [3:0]  CODE_6MS          = 4'hA;
    localparam logic [3:0]  CODE_12MS         = 4'hB;
    localparam logic [3:0]  CODE_23MS         = 4'hC;

    // delays in 100 us ticks
    localparam logic [7:0]  TICKS_0P4MS       = 8'h04;
    localparam logic [7:0]  TICKS_0P7MS       = 8'h07;
    localparam logic [7:0]  TICKS_1P5MS       = 8'h0F;
    localparam logic [7:0]  TICKS_3MS         = 8'h1E;
    localparam logic [7:0]  TICKS_6MS         = 8'h3C;
    localparam logic [7:0]  TICKS_12MS        = 8'h78;
    localparam logic [7:0]  TICKS_23MS        = 8'hE6;

    typedef enum logic [1:0] {
        DIP_ACC_IMAGE  = 2'b00,
        DIP_ACC_OBJECT = 2'b01,
        DIP_ACC_SUBIDX = 2'b10
    } dip_acc_kind_t;

    typedef struct packed {
        dip_acc_kind_t kind;
        logic [15:0]   addr;
        logic [7:0]    sub;
    } dip_rd_req_t;

    typedef struct packed {
        logic       err;
        logic [7:0] data;
    } dip_rd_rsp_t;

    typedef struct packed {
        logic run;
        logic fault;
    } dip_module_led_t;

endpackage : dip_pkg

/* design/dip_chan_filter.sv */
`timescale 1ns/1ps
`default_nettype none

module dip_chan_filter
    import dip_pkg::*;
#(
    parameter int unsigned CNT_W = TICK_W
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             tick,
    input  wire logic             enable,
    input  wire logic [CNT_W-1:0] delay_ticks,
    input  wire logic             din,
    output logic                  level
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    wire              differs  = (din != level);
    wire              expired  = (next_count >= delay_ticks);

    assign next_count = count + CNT_W'(1);

    // rising and falling edges take the same delay
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            level <= 1'b0;
            count <= '0;
        end else if (!enable || !differs) begin
            level <= enable ? level : din;
            count <= '0;
        end else if (tick) begin
            level <= expired ? din : level;
            count <= expired ? '0 : next_count;
        end
    end

endmodule : dip_chan_filter

`default_nettype wire

/* design/dip_input_port.sv */
`timescale 1ns/1ps
`default_nettype none

module dip_input_port
    import dip_pkg::*;
#(
    parameter int unsigned TICK_LEN   = TICK_CYCLES,
    parameter int unsigned BLINK_HALF = BLINK_HALF_TICKS
) (
    input  wire logic                mclk,
    input  wire logic                reset_n,
    input  wire logic [CHANNELS-1:0] input_channel,
    input  wire logic                rd_req,
    input  wire dip_rd_req_t         rd_cmd,
    output dip_rd_rsp_t              rd_rsp,
    output logic                     rd_valid,
    input  wire logic                param_wr,
    input  wire logic [BYTE_W-1:0]   param_wr_data,
    input  wire logic                out_wr,
    input  wire logic [BYTE_W-1:0]   out_wr_data,
    input  wire logic                bus_comm_ok,
    input  wire logic                module_error,
    output logic [CHANNELS-1:0]      channel_led,
    output dip_module_led_t          module_led,
    output logic [BYTE_W-1:0]        input_delay_parameter,
    output logic                     config_error
);

    function automatic logic [8:0] delay_lookup(input logic [3:0] code);
        logic [8:0] res;
        res = 9'h000;
        unique case (code)
            CODE_0P4MS: res = {1'b1, TICKS_0P4MS};
            CODE_0P7MS: res = {1'b1, TICKS_0P7MS};
            CODE_1P5MS: res = {1'b1, TICKS_1P5MS};
            CODE_3MS:   res = {1'b1, TICKS_3MS};
            CODE_6MS:   res = {1'b1, TICKS_6MS};
            CODE_12MS:  res = {1'b1, TICKS_12MS};
            CODE_23MS:  res = {1'b1, TICKS_23MS};
            default:    res = 9'h000;
        endcase
        return res;
    endfunction : delay_lookup

    localparam int unsigned TICK_CW  = $clog2(TICK_LEN + 1);
    localparam int unsigned BLINK_CW = $clog2(BLINK_HALF + 1);

    // two-stage synchroniser
    // field contacts are asynchronous to mclk
    logic [CHANNELS-1:0] sync_meta;
    logic [CHANNELS-1:0] sync_in;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync_meta <= '0;
            sync_in   <= '0;
        end else begin
            sync_meta <= input_channel;
            sync_in   <= sync_meta;
        end
    end

    // 100 us time base shared by all channels
    // free running, so a delay may come out up to one tick short
    logic [TICK_CW-1:0] tick_cnt;
    wire                tick          = (tick_cnt == TICK_CW'(TICK_LEN - 1));
    wire [TICK_CW-1:0]  next_tick_cnt = tick ? '0 : tick_cnt + TICK_CW'(1);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    wire [8:0] wr_lookup = delay_lookup(param_wr_data[PARAM_CODE_MSB:0]);
    wire       wr_ok     = wr_lookup[8];
    wire [8:0] cur_look  = delay_lookup(input_delay_parameter[PARAM_CODE_MSB:0]);
    wire [TICK_W-1:0] delay_ticks = cur_look[TICK_W-1:0];
    wire       filter_en = input_delay_parameter[PARAM_EN_BIT];
    // reserved bits are kept as written; only the parameter read returns them
    wire [BYTE_W-1:0] next_input_delay_parameter = wr_ok ? param_wr_data : input_delay_parameter;

    // reset to 89h; bad code kept out
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            input_delay_parameter <= PARAM_RESET;
            config_error          <= 1'b0;
        end else if (param_wr) begin
            input_delay_parameter <= next_input_delay_parameter;
            config_error          <= !wr_ok;
        end
    end

    // one filter per channel, shared time setting
    logic [CHANNELS-1:0] filtered;

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        dip_chan_filter #(
            .CNT_W       (TICK_W)
        ) u_filter (
            .mclk        (mclk),
            .reset_n     (reset_n),
            .tick        (tick),
            .enable      (filter_en),
            .delay_ticks (delay_ticks),
            .din         (sync_in[ch]),
            .level       (filtered[ch])
        );
    end

    // whole image moves in one cycle
    // one register for all bits, so no read can tear
    logic [CHANNELS-1:0] image;
    logic [BYTE_W-1:0]   high_snap;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            image <= '0;
        end else begin
            image <= filtered;
        end
    end

    wire [BYTE_W-1:0] image_low  = image[BYTE_W-1:0];
    wire [BYTE_W-1:0] image_high = image[CHANNELS-1:BYTE_W];

    wire is_image  = (rd_cmd.kind == DIP_ACC_IMAGE);
    wire is_object = (rd_cmd.kind == DIP_ACC_OBJECT);
    wire is_subidx = (rd_cmd.kind == DIP_ACC_SUBIDX);
    wire hit_low   = (is_image && rd_cmd.addr == IMG_OFS_LOW)
                   || (is_object && rd_cmd.addr == OBJ_IDX_LOW);
    wire hit_high  = (is_image && rd_cmd.addr == IMG_OFS_HIGH)
                   || (is_object && rd_cmd.addr == OBJ_IDX_HIGH);
    wire hit_param = (is_object || is_subidx) && rd_cmd.addr == OBJ_IDX_PARAM
                   && rd_cmd.sub == OBJ_SUB_PARAM;
    // channel subindex under the image index
    wire hit_chan  = is_subidx && rd_cmd.addr == OBJ_IDX_LOW
                   && rd_cmd.sub >= OBJ_SUB_FIRST && rd_cmd.sub <= OBJ_SUB_LAST;
    wire [7:0] chan_sel = rd_cmd.sub - OBJ_SUB_FIRST;
    wire       chan_bit = image[chan_sel[3:0]];

    wire [BYTE_W-1:0] next_rd_data =
        hit_low   ? image_low :
        hit_high  ? high_snap :
        hit_param ? input_delay_parameter :
        hit_chan  ? {{(BYTE_W-1){1'b0}}, chan_bit} : '0;
    wire next_rd_err = !(hit_low || hit_high || hit_param || hit_chan);

    // low-byte read freezes the high byte for the following read
    // limitation: a lone high read returns the last snapshot, not live data
    wire [BYTE_W-1:0] next_high_snap = (rd_req && hit_low) ? image_high : high_snap;
    dip_rd_rsp_t      next_rd_rsp;

    assign next_rd_rsp = rd_req ? {next_rd_err, next_rd_data} : rd_rsp;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            high_snap <= '0;
            rd_rsp    <= '0;
            rd_valid  <= 1'b0;
        end else begin
            high_snap <= next_high_snap;
            rd_valid  <= rd_req;
            rd_rsp    <= next_rd_rsp;
        end
    end

    wire out_area_sink = out_wr & (|out_wr_data);

    // 2 Hz blink from the tick
    logic [BLINK_CW-1:0] blink_cnt;
    logic                blink;
    wire                 blink_wrap     = (blink_cnt == BLINK_CW'(BLINK_HALF - 1));
    wire [BLINK_CW-1:0]  next_blink_cnt = blink_wrap ? '0 : blink_cnt + BLINK_CW'(1);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            blink_cnt <= '0;
            blink     <= 1'b0;
        end else if (tick) begin
            blink_cnt <= next_blink_cnt;
            blink     <= blink_wrap ? !blink : blink;
        end
    end

    // a configuration error outranks a steady module error
    wire next_fault = config_error ? blink : module_error;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            channel_led <= '0;
            module_led  <= '0;
        end else begin
            channel_led      <= image;
            module_led.run   <= bus_comm_ok;
            module_led.fault <= next_fault;
        end
    end

endmodule : dip_input_port

`default_nettype wire

/* sim/dip_input_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dip_input_port_asserts
    import dip_pkg::*;
(
    input wire logic                mclk,
    input wire logic                reset_n,
    input wire logic [15:0]         input_channel,
    input wire logic                rd_req,
    input wire dip_rd_req_t         rd_cmd,
    input wire dip_rd_rsp_t         rd_rsp,
    input wire logic                rd_valid,
    input wire logic                param_wr,
    input wire logic [7:0]          param_wr_data,
    input wire logic                out_wr,
    input wire logic [7:0]          out_wr_data,
    input wire logic                bus_comm_ok,
    input wire logic                module_error,
    input wire logic [15:0]         channel_led,
    input wire dip_module_led_t     module_led,
    input wire logic [7:0]          input_delay_parameter,
    input wire logic                config_error
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire bad_code = (param_wr_data[3:0] < CODE_0P4MS) || (param_wr_data[3:0] > CODE_23MS);
    wire sub_rd = rd_req && rd_cmd.kind == DIP_ACC_SUBIDX && rd_cmd.addr == OBJ_IDX_LOW;
    sequence s_err_steady;
        (!config_error && module_error) [*2];
    endsequence
    sequence s_comm_steady;
        bus_comm_ok [*2];
    endsequence
    a_read_answered: assert property (rd_req |=> rd_valid) else $error("read not answered");
    a_no_spurious: assert property (!rd_req |=> !rd_valid) else $error("valid without read");
    a_unmapped_err: assert property (rd_req && rd_cmd.kind == 2'b11 |=> rd_rsp.err && rd_rsp.data == 8'h00)
        else $error("unmapped read not refused");
    a_sub_one_bit: assert property (sub_rd && rd_cmd.sub inside {[OBJ_SUB_FIRST:OBJ_SUB_LAST]}
        |=> !rd_rsp.err && rd_rsp.data[7:1] == 7'h00) else $error("subindex read not one bit");
    a_bad_code_kept: assert property (param_wr && bad_code |=> config_error && $stable(input_delay_parameter))
        else $error("bad delay code accepted");
    a_good_code_taken: assert property (param_wr && !bad_code
        |=> !config_error && input_delay_parameter == $past(param_wr_data)) else $error("parameter not stored");
    a_run_tracks: assert property (s_comm_steady |=> module_led.run) else $error("run dark with bus ok");
    a_fault_error: assert property (s_err_steady |=> module_led.fault) else $error("fault dark on error");
    // half period is 3 ticks of 4 cycles, one cycle of slack
    a_fault_blinks: assert property (config_error && $rose(module_led.fault)
        |-> ##[1:13] (!module_led.fault || !config_error)) else $error("fault not blinking");
endmodule : dip_input_port_asserts
bind dip_input_port dip_input_port_asserts chk_i (.mclk, .reset_n, .input_channel, .rd_req, .rd_cmd, .rd_rsp,
    .rd_valid, .param_wr, .param_wr_data, .out_wr, .out_wr_data, .bus_comm_ok, .module_error, .channel_led,
    .module_led, .input_delay_parameter, .config_error);
`default_nettype wire

/* sim/dip_field_src.sv */
`timescale 1ns/1ps
`default_nettype none
// field contacts, changed away from the sampling edge
module dip_field_src (
    input  wire logic        mclk,
    input  wire logic [15:0] pattern,
    output logic [15:0]      input_channel
);
    always @(negedge mclk) begin
        input_channel <= pattern;
    end
endmodule : dip_field_src
`default_nettype wire

/* sim/dip_input_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dip_input_port_tb;
    import dip_pkg::*;
    logic            mclk = 1'b0;
    logic            reset_n = 1'b0;
    logic [15:0]     pattern = 16'h0000;
    logic [15:0]     input_channel;
    logic            rd_req = 1'b0;
    dip_rd_req_t     rd_cmd = '0;
    dip_rd_rsp_t     rd_rsp;
    logic            rd_valid;
    logic            param_wr = 1'b0;
    logic [7:0]      param_wr_data = 8'h00;
    logic            out_wr = 1'b0;
    logic [7:0]      out_wr_data = 8'h00;
    logic            bus_comm_ok = 1'b1;
    logic            module_error = 1'b0;
    logic [15:0]     channel_led;
    dip_module_led_t module_led;
    logic [7:0]      input_delay_parameter;
    logic            config_error;
    int              num_errors = 0;
    int              num_checks = 0;
    logic            fault_prev;
    int              num_toggles;
    always #2.5 mclk = ~mclk;
    dip_field_src src (.mclk, .pattern, .input_channel);
    // short tick so the 3 ms default is 120 cycles
    dip_input_port #(.TICK_LEN(4), .BLINK_HALF(3)) uut (.mclk, .reset_n, .input_channel, .rd_req, .rd_cmd,
        .rd_rsp, .rd_valid, .param_wr, .param_wr_data, .out_wr, .out_wr_data, .bus_comm_ok, .module_error,
        .channel_led, .module_led, .input_delay_parameter, .config_error);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [1:0] k, input logic [15:0] a, input logic [7:0] s, input logic [8:0] exp);
        @(negedge mclk);
        rd_req = 1'b1;
        rd_cmd = '{dip_acc_kind_t'(k), a, s};
        @(negedge mclk);
        rd_req = 1'b0;
        chk({6'h00, rd_valid, rd_rsp}, {6'h00, 1'b1, exp});
    endtask : rd
    task automatic pw(input logic [7:0] d);
        @(negedge mclk);
        param_wr = 1'b1;
        param_wr_data = d;
        @(negedge mclk);
        param_wr = 1'b0;
    endtask : pw
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        chk({8'h00, input_delay_parameter}, 16'h0089);
        pattern = 16'hA55A;
        repeat (100) @(negedge mclk);
        rd(0, 16'h0000, 8'h00, 9'h000);
        repeat (40) @(negedge mclk);
        rd(0, 16'h0000, 8'h00, 9'h05A);
        rd(0, 16'h0001, 8'h00, 9'h0A5);
        rd(1, 16'h6000, 8'h00, 9'h05A);
        rd(1, 16'h6001, 8'h00, 9'h0A5);
        for (int i = 0; i < 16; i++) begin
            rd(2, 16'h6000, 8'(i + 1), {8'h00, pattern[i]});
        end
        rd(3, 16'h0000, 8'h00, 9'h100);
        rd(1, 16'h3100, 8'h01, 9'h089);
        chk(channel_led, 16'hA55A);
        out_wr = 1'b1;
        out_wr_data = 8'hFF;
        @(negedge mclk);
        out_wr = 1'b0;
        repeat (5) @(negedge mclk);
        chk(channel_led, 16'hA55A);
        chk({7'h00, config_error, input_delay_parameter}, 16'h0089);
        pw(8'h05);
        chk({7'h00, config_error, input_delay_parameter}, 16'h0189);
        // half period is 3 ticks of 4 cycles: two changes in 24 cycles
        repeat (2) @(negedge mclk);
        fault_prev = module_led.fault;
        num_toggles = 0;
        repeat (24) begin
            @(negedge mclk);
            num_toggles += int'(module_led.fault != fault_prev);
            fault_prev = module_led.fault;
        end
        chk(16'(num_toggles), 16'h0002);
        // bit 7 clear bypasses the filter, reserved bits kept
        pw(8'h76);
        chk({7'h00, config_error, input_delay_parameter}, 16'h0076);
        pattern = 16'hFFFF;
        repeat (8) @(negedge mclk);
        rd(0, 16'h0000, 8'h00, 9'h0FF);
        pattern = 16'h0000;
        repeat (8) @(negedge mclk);
        rd(0, 16'h0001, 8'h00, 9'h0FF);
        // code 06h is 4 ticks, 16 cycles, on both edges
        pw(8'h86);
        chk({7'h00, config_error, input_delay_parameter}, 16'h0086);
        pattern = 16'h0F0F;
        repeat (8) @(negedge mclk);
        rd(0, 16'h0000, 8'h00, 9'h000);
        repeat (16) @(negedge mclk);
        rd(0, 16'h0000, 8'h00, 9'h00F);
        pattern = 16'h0000;
        repeat (8) @(negedge mclk);
        rd(0, 16'h0000, 8'h00, 9'h00F);
        repeat (16) @(negedge mclk);
        rd(0, 16'h0000, 8'h00, 9'h000);
        module_error = 1'b1;
        bus_comm_ok = 1'b0;
        repeat (3) @(negedge mclk);
        chk({14'h0000, module_led}, 16'h0001);
        bus_comm_ok = 1'b1;
        repeat (3) @(negedge mclk);
        chk({14'h0000, module_led}, 16'h0003);
        // second reset mid-run brings back the 3 ms default
        reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        chk({7'h00, config_error, input_delay_parameter}, 16'h0089);
        chk(channel_led, 16'h0000);
        summarize();
    end
endmodule : dip_input_port_tb
`default_nettype wire
